/* File: bench/srap_asserts.sv */
// assertions on the two-wire link between host end and device end
`timescale 1ns/100ps
module srap_asserts (
	input wire logic       ref_clk,
	input wire logic       rst,
	input wire logic       scl,
	input wire logic       sda,
	input wire logic       devSdaOeN,
	input wire logic [1:0] strap
);
	logic       sclQ;
	logic       sdaQ;
	logic       rdDir;
	logic       inFrame;
	logic [3:0] bitCnt;
	logic [7:0] byteCnt;
	logic [7:0] shReg;
	wire        startC = scl && sclQ && sdaQ && !sda;
	wire        stopC  = scl && sclQ && !sdaQ && sda;
	wire        riseC  = scl && !sclQ;

	// bit and byte position within a frame
	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			sclQ <= 1'b1;
			sdaQ <= 1'b1;
			rdDir <= 1'b0;
			inFrame <= 1'b0;
			bitCnt <= 4'h0;
			byteCnt <= 8'h00;
			shReg <= 8'h00;
		end else begin
			sclQ <= scl;
			sdaQ <= sda;
			if (startC) begin
				inFrame <= 1'b1;
				bitCnt <= 4'h0;
				byteCnt <= 8'h00;
			end else if (stopC) begin
				inFrame <= 1'b0;
			end else if (riseC) begin
				bitCnt <= (bitCnt == 4'h9) ? 4'h1 : bitCnt + 4'h1;
				if (bitCnt == 4'h9) byteCnt <= byteCnt + 8'h01;
				if (bitCnt != 4'h8) shReg <= {shReg[6:0], sda};
				if (bitCnt == 4'h8 && byteCnt == 8'h00) rdDir <= shReg[0];
			end
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);

	sequence ninthRise;
		riseC && bitCnt == 4'h8;
	endsequence
	sequence addrHit;
		byteCnt == 8'h00 && shReg[7:1] == {srap_pkg::I2C_ADDR_FIXED, strap};
	endsequence
	sequence addrMiss;
		byteCnt == 8'h00 && shReg[7:1] != {srap_pkg::I2C_ADDR_FIXED, strap};
	endsequence

	a_dev_stable_high: assert property (scl && sclQ |-> $stable(devSdaOeN))
		else $error("device data pull changed while clock high");
	a_addr_ack: assert property (ninthRise ##0 addrHit |-> !devSdaOeN)
		else $error("matching address not acknowledged");
	a_addr_ignore: assert property (ninthRise ##0 addrMiss |-> devSdaOeN)
		else $error("foreign address acknowledged");
	a_write_ack_held: assert property (ninthRise ##0 (byteCnt != 8'h00 && !rdDir) |-> !devSdaOeN [*4])
		else $error("write byte not acknowledged");
	a_read_ack_free: assert property (ninthRise ##0 (byteCnt != 8'h00 && rdDir) |-> devSdaOeN)
		else $error("device holds data line in master ack slot");
	a_idle_quiet: assert property (!inFrame |-> devSdaOeN)
		else $error("device pulls data line outside a frame");
	a_start_hold: assert property (startC |-> scl [*3])
		else $error("clock dropped right after start");
	a_stop_framed: assert property (stopC |-> bitCnt == 4'h1)
		else $error("stop not on a byte boundary");
endmodule : srap_asserts

/* File: bench/tb_top.sv */
// self-checking bench joining host and device ends of both variants
`timescale 1ns/100ps
module tb_top;
	localparam int WAIT_MAX = 20000;
	logic       ref_clk, rst, reqI, reqS, startRd;
	logic [7:0] startPtr, startLen, txData, txBase, txIdx, shI, shS, stbCntI, stbCntS;
	logic [1:0] devAddr, strap;
	logic [3:0] bitI, bitS, ptrI, ptrS;
	logic       takeI, takeS, rvI, rvS, busyI, busyS, nackI, nackS, stbI, stbS;
	logic [7:0] rxI, rxS, wdI, wdS;
	logic [7:0] bankI [16];
	logic [7:0] bankS [16];
	logic [7:0] rdQ [$];
	int         err_total, checks_done;
	wire  [7:0] rdI = bankI[ptrI];
	wire  [7:0] rdS = bankS[ptrS];

	srap_if lnkI();
	srap_if lnkS();
	srap_host #(.VARIANT(srap_pkg::VAR_I2C), .QTR_CYC(6)) i_srap_host_i2c (.ref_clk(ref_clk), .rst(rst),
		.link(lnkI), .startReq(reqI), .startRd(startRd), .startPtr(startPtr), .startLen(startLen),
		.devAddr(devAddr), .txData(txData), .txTake(takeI), .rxData(rxI), .rxValid(rvI), .busy(busyI), .nack(nackI));
	srap_device #(.VARIANT(srap_pkg::VAR_I2C)) i_srap_device_i2c (.ref_clk(ref_clk), .rst(rst), .link(lnkI),
		.strap_addr_hi(strap[1]), .strap_addr_lo(strap[0]), .regPtr(ptrI), .regWrStb(stbI), .regWdata(wdI),
		.regRdata(rdI));
	srap_host #(.VARIANT(srap_pkg::VAR_SPI)) i_srap_host_spi (.ref_clk(ref_clk), .rst(rst),
		.link(lnkS), .startReq(reqS), .startRd(startRd), .startPtr(startPtr), .startLen(startLen),
		.devAddr(devAddr), .txData(txData), .txTake(takeS), .rxData(rxS), .rxValid(rvS), .busy(busyS), .nack(nackS));
	srap_device #(.VARIANT(srap_pkg::VAR_SPI)) i_srap_device_spi (.ref_clk(ref_clk), .rst(rst), .link(lnkS),
		.strap_addr_hi(strap[1]), .strap_addr_lo(strap[0]), .regPtr(ptrS), .regWrStb(stbS), .regWdata(wdS),
		.regRdata(rdS));
	srap_asserts i_srap_asserts (.ref_clk(ref_clk), .rst(rst), .scl(lnkI.scl), .sda(lnkI.sda),
		.devSdaOeN(lnkI.devSdaOeN), .strap(strap));

	// register banks, write data feed and read collection
	always @(posedge ref_clk) begin
		if (stbI) begin
			bankI[ptrI] <= wdI;
			stbCntI <= stbCntI + 8'h01;
		end
		if (stbS) begin
			bankS[ptrS] <= wdS;
			stbCntS <= stbCntS + 8'h01;
		end
		if (takeI || takeS) begin
			txIdx <= txIdx + 8'h01;
			txData <= txBase + txIdx + 8'h01;
		end
		if (rvI || rvS) rdQ.push_back(rvI ? rxI : rxS);
	end

	// first byte seen on each wire
	always @(posedge lnkI.scl) begin
		if (bitI < 4'h8) shI <= {shI[6:0], lnkI.sda};
		if (bitI < 4'h8) bitI <= bitI + 4'h1;
	end
	always @(negedge lnkI.sda) if (lnkI.scl) bitI <= 4'h0;
	always @(posedge lnkS.scl) begin
		if (bitS < 4'h8) shS <= {shS[6:0], lnkS.sdio};
		if (bitS < 4'h8) bitS <= bitS + 4'h1;
	end
	always @(negedge lnkS.ceN) bitS <= 4'h0;

	initial begin
		ref_clk = 1'b0;
		forever #10 ref_clk = ~ref_clk;
	end

	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task automatic close_out();
		$display("checks_done=%0d err_total=%0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask : close_out

	// one whole transfer on either link
	task automatic xfer(input bit spi, input logic rd, input logic [7:0] ptr, input logic [7:0] len,
		input logic [1:0] adr, input logic [7:0] base);
		int n;
		n = 0;
		@(posedge ref_clk);
		startRd <= rd;
		startPtr <= ptr;
		startLen <= len;
		devAddr <= adr;
		txBase <= base;
		txData <= base;
		txIdx <= 8'h00;
		stbCntI <= 8'h00;
		stbCntS <= 8'h00;
		rdQ.delete();
		if (spi) reqS <= 1'b1;
		else reqI <= 1'b1;
		@(posedge ref_clk);
		reqS <= 1'b0;
		reqI <= 1'b0;
		do begin
			@(posedge ref_clk);
			#1;
			n++;
		end while (n < WAIT_MAX && (n < 4 || busyI !== 1'b0 || busyS !== 1'b0));
		if (n >= WAIT_MAX) begin
			err_total++;
			close_out();
		end
		chk(spi ? shS : shI, spi ? {rd, 2'h0, ptr[4:0]} : {srap_pkg::I2C_ADDR_FIXED, adr, rd});
	endtask : xfer

	// burst across the top of the map, pointer parks
	task automatic t_write_sat(input bit spi);
		xfer(spi, 1'b0, 8'h0e, 8'h04, 2'h2, 8'ha0);
		chk(spi ? bankS[14] : bankI[14], 8'ha0);
		chk(spi ? bankS[15] : bankI[15], 8'ha1);
		chk(spi ? stbCntS : stbCntI, 8'h02);
		$display("test write_sat done");
	endtask : t_write_sat

	// read across the top of the map on either link
	task automatic t_read_sat(input bit spi);
		if (!spi) xfer(1'b0, 1'b0, 8'h0e, 8'h00, 2'h2, 8'h00);
		chk(stbCntI, 8'h00);
		xfer(spi, 1'b1, 8'h0e, 8'h03, 2'h2, 8'h00);
		chk(8'(rdQ.size()), 8'h03);
		chk(rdQ[0], 8'ha0);
		chk(rdQ[1], 8'ha1);
		chk(rdQ[2], 8'h00);
		$display("test read_sat done");
	endtask : t_read_sat

	// pointer out of range, data dropped
	task automatic t_bad_ptr(input bit spi);
		xfer(spi, 1'b0, spi ? 8'h1f : 8'h20, 8'h02, 2'h2, 8'h55);
		chk(spi ? stbCntS : stbCntI, 8'h00);
		chk({7'h00, spi ? nackS : nackI}, 8'h00);
		chk(spi ? bankS[15] : bankI[15], 8'ha1);
		$display("test bad_ptr done");
	endtask : t_bad_ptr

	// low end of map, then a foreign address
	task automatic t_addr();
		xfer(1'b0, 1'b0, 8'h00, 8'h01, 2'h2, 8'h3c);
		chk(bankI[0], 8'h3c);
		xfer(1'b0, 1'b0, 8'h03, 8'h01, 2'h1, 8'h77);
		chk({7'h00, nackI}, 8'h01);
		chk(stbCntI, 8'h00);
		@(posedge ref_clk);
		strap <= 2'h1;
		xfer(1'b0, 1'b0, 8'h03, 8'h01, 2'h1, 8'h77);
		chk({7'h00, nackI}, 8'h00);
		chk(bankI[3], 8'h77);
		$display("test addr done");
	endtask : t_addr

	initial begin
		err_total = 0;
		checks_done = 0;
		for (int k = 0; k < 16; k++) begin
			bankI[k] = 8'h00;
			bankS[k] = 8'h00;
		end
		rst = 1'b1;
		{reqI, reqS, startRd} = 3'h0;
		{startPtr, startLen, txData, txBase, txIdx, stbCntI, stbCntS} = '0;
		devAddr = 2'h2;
		strap = 2'h2;
		{bitI, bitS} = 8'hff;
		repeat (2) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (3) @(posedge ref_clk);
		for (int v = 0; v < 2; v++) begin
			t_write_sat(v[0]);
			t_read_sat(v[0]);
			t_bad_ptr(v[0]);
		end
		t_addr();
		close_out();
	end
endmodule : tb_top

/* File: design/srap_device.sv */
// device end: two-wire or three-wire slave feeding a byte register port
// What this block does
// - master starts only on idle bus
// - data moves only while clock low
// - acknowledge every received write byte
// - accept byte, stop or restart after acknowledge
// - read ends on stop or start
// - first write byte is the pointer
// - bad pointer: discard data, still acknowledge
// - any data count, pointer steps per byte
// - pointer parks at 10h
// - read shifts out from current pointer
// - match address 01110 plus two straps
// - address lsb selects write or read
// - high select holds interface reset
// - host toggles select between transfers
// - sample on rise, drive after fall
// - read data on shared data pin
// - bytes shift msb first
// - command byte: direction, 00, pointer
// - bad command pointer ignores transfer
// - pointer steps after each data byte
// - host may read back to check health
`timescale 1ns/100ps
module srap_device #(
	parameter int VARIANT = srap_pkg::VAR_I2C
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	srap_if.dev             link,
	input  wire logic       strap_addr_hi,
	input  wire logic       strap_addr_lo,
	output logic [3:0]      regPtr,
	output logic            regWrStb,
	output logic [7:0]      regWdata,
	input  wire logic [7:0] regRdata
);
	typedef enum {I_IDLE, I_ADDR, I_PTR, I_WDATA, I_ACK, I_RDATA, I_RACK} srapIst_t;

	typedef struct packed {
		logic [1:0] sclSy;
		logic [1:0] sdaSy;
		logic       sclP;
		logic       sdaP;
		logic [1:0] hiSy;
		logic [1:0] loSy;
		srapIst_t   st;
		srapIst_t   after;
		logic [3:0] bitCnt;
		logic [7:0] sh;
		logic [4:0] ptr;
		logic       discard;
		logic       mstNack;
		logic       sdaOeN;
		logic [3:0] regPtr;
		logic       regWrStb;
		logic [7:0] regWdata;
		logic [2:0] tglSy;
		logic       fetch;
		logic [7:0] rdHold;
	} srapRef_t;

	typedef struct packed {
		logic [2:0] bitCnt;
		logic [7:0] sh;
		logic       cmdDone;
		logic       rd;
		logic       bad;
		logic [4:0] ptr;
	} srapLnk_t;

	typedef struct packed {
		logic       tgl;
		logic       pkWr;
		logic       pkNull;
		logic [3:0] pkPtr;
		logic [7:0] pkData;
	} srapPk_t;

	typedef struct packed {
		logic [7:0] sh;
		logic       drv;
	} srapTx_t;

	srapRef_t r;
	srapRef_t next_r;
	srapLnk_t m;
	srapLnk_t next_m;
	srapPk_t  pk;
	srapPk_t  next_pk;
	srapTx_t  tx;
	srapTx_t  next_tx;

	// reference clock side: two-wire slave and register port
	always_comb begin
		logic       sclRise;
		logic       sclFall;
		logic       startC;
		logic       stopC;
		logic [7:0] rdB;
		next_r = r;
		next_r.regWrStb = 1'b0;
		next_r.sclSy = {r.sclSy[0], link.scl};
		next_r.sdaSy = {r.sdaSy[0], link.sda};
		next_r.sclP = r.sclSy[1];
		next_r.sdaP = r.sdaSy[1];
		next_r.hiSy = {r.hiSy[0], strap_addr_hi};
		next_r.loSy = {r.loSy[0], strap_addr_lo};
		next_r.tglSy = {r.tglSy[1:0], pk.tgl};
		sclRise = r.sclSy[1] & ~r.sclP;
		sclFall = ~r.sclSy[1] & r.sclP;
		startC = r.sclSy[1] & r.sclP & r.sdaP & ~r.sdaSy[1];
		stopC = r.sclSy[1] & r.sclP & ~r.sdaP & r.sdaSy[1];
		rdB = srap_pkg::rdSel(r.ptr, regRdata);
		if (VARIANT == srap_pkg::VAR_I2C) begin
			next_r.regPtr = r.ptr[3:0];
			if (startC) begin
				next_r.st = I_ADDR;
				next_r.bitCnt = 4'h0;
				next_r.sdaOeN = 1'b1;
			end else if (stopC) begin
				next_r.st = I_IDLE;
				next_r.sdaOeN = 1'b1;
			end else begin
				case (r.st)
					I_ADDR, I_PTR, I_WDATA: begin
						if (sclRise && r.bitCnt < srap_pkg::I2C_ACK_BIT) begin
							next_r.sh = {r.sh[6:0], r.sdaSy[1]};
							next_r.bitCnt = r.bitCnt + 4'h1;
						end else if (sclFall && r.bitCnt == srap_pkg::I2C_ACK_BIT) begin
							next_r.bitCnt = 4'h0;
							next_r.st = I_ACK;
							next_r.sdaOeN = 1'b0;
							next_r.after = I_WDATA;
							if (r.st == I_ADDR) begin
								next_r.discard = 1'b0;
								if (r.sh[7:1] != {srap_pkg::I2C_ADDR_FIXED, r.hiSy[1], r.loSy[1]}) begin
									next_r.st = I_IDLE;
									next_r.sdaOeN = 1'b1;
								end else if (r.sh[srap_pkg::I2C_DIR_BIT]) begin
									next_r.after = I_RDATA;
								end else begin
									next_r.after = I_PTR;
								end
							end else if (r.st == I_PTR) begin
								if (r.sh[7:4] == 4'h0) begin
									next_r.ptr = r.sh[4:0];
								end else begin
									next_r.discard = 1'b1;
								end
							end else begin
								if (!r.discard && r.ptr != srap_pkg::PTR_SAT) begin
									next_r.regWrStb = 1'b1;
									next_r.regWdata = r.sh;
								end
								next_r.ptr = srap_pkg::ptrNext(r.ptr);
							end
						end
					end
					I_ACK: begin
						if (sclFall) begin
							next_r.sdaOeN = 1'b1;
							next_r.st = r.after;
							if (r.after == I_RDATA) begin
								next_r.sh = rdB;
								next_r.sdaOeN = rdB[7];
								next_r.ptr = srap_pkg::ptrNext(r.ptr);
							end
						end
					end
					I_RDATA: begin
						if (sclFall) begin
							if (r.bitCnt == 4'h7) begin
								next_r.sdaOeN = 1'b1;
								next_r.bitCnt = 4'h0;
								next_r.st = I_RACK;
							end else begin
								next_r.bitCnt = r.bitCnt + 4'h1;
								next_r.sh = {r.sh[6:0], 1'b0};
								next_r.sdaOeN = r.sh[6];
							end
						end
					end
					I_RACK: begin
						if (sclRise) begin
							next_r.mstNack = r.sdaSy[1];
						end
						if (sclFall) begin
							if (r.mstNack) begin
								next_r.st = I_IDLE;
							end else begin
								next_r.st = I_RDATA;
								next_r.sh = rdB;
								next_r.sdaOeN = rdB[7];
								next_r.ptr = srap_pkg::ptrNext(r.ptr);
							end
						end
					end
					default: begin
						next_r.sdaOeN = 1'b1;
					end
				endcase
			end
		end else begin
			if (r.tglSy[2] != r.tglSy[1]) begin
				next_r.regPtr = pk.pkPtr;
				if (pk.pkWr) begin
					next_r.regWrStb = 1'b1;
					next_r.regWdata = pk.pkData;
				end else begin
					next_r.fetch = 1'b1;
				end
			end
			if (r.fetch) begin
				next_r.fetch = 1'b0;
				next_r.rdHold = pk.pkNull ? 8'h00 : regRdata;
			end
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			r <= '0;
			r.sclSy <= 2'h3;
			r.sdaSy <= 2'h3;
			r.sclP <= 1'b1;
			r.sdaP <= 1'b1;
			r.sdaOeN <= 1'b1;
		end else begin
			r <= next_r;
		end
	end

	// link clock side: three-wire receive, command parse and requests
	always_comb begin
		logic [7:0] byteIn;
		byteIn = {m.sh[6:0], link.sdio};
		next_m = m;
		next_pk = pk;
		next_m.sh = byteIn;
		next_m.bitCnt = m.bitCnt + 3'h1;
		if (m.bitCnt == 3'h7) begin
			if (!m.cmdDone) begin
				next_m.cmdDone = 1'b1;
				next_m.rd = byteIn[srap_pkg::SPI_DIR_BIT];
				next_m.ptr = byteIn[4:0];
				next_m.bad = byteIn[4:0] > srap_pkg::PTR_LAST;
				if (byteIn[srap_pkg::SPI_DIR_BIT] && byteIn[4:0] <= srap_pkg::PTR_LAST) begin
					next_pk.tgl = ~pk.tgl;
					next_pk.pkWr = 1'b0;
					next_pk.pkPtr = byteIn[3:0];
					next_pk.pkNull = 1'b0;
				end
			end else if (!m.bad) begin
				next_m.ptr = srap_pkg::ptrNext(m.ptr);
				if (m.rd) begin
					next_pk.tgl = ~pk.tgl;
					next_pk.pkWr = 1'b0;
					next_pk.pkPtr = 4'(srap_pkg::ptrNext(m.ptr));
					next_pk.pkNull = srap_pkg::ptrNext(m.ptr) == srap_pkg::PTR_SAT;
				end else if (m.ptr != srap_pkg::PTR_SAT) begin
					next_pk.tgl = ~pk.tgl;
					next_pk.pkWr = 1'b1;
					next_pk.pkPtr = m.ptr[3:0];
					next_pk.pkData = byteIn;
				end
			end
		end
	end

	always_ff @(posedge link.scl or posedge link.ceN) begin
		if (link.ceN) begin
			m <= '0;
		end else begin
			m <= next_m;
		end
	end

	always_ff @(posedge link.scl or posedge rst) begin
		if (rst) begin
			pk <= '0;
		end else begin
			pk <= next_pk;
		end
	end

	// falling edge launches read bits on the shared line
	always_comb begin
		next_tx = tx;
		next_tx.drv = m.cmdDone & m.rd & ~m.bad;
		if (next_tx.drv) begin
			next_tx.sh = (m.bitCnt == 3'h0) ? r.rdHold : {tx.sh[6:0], 1'b0};
		end
	end

	always_ff @(negedge link.scl or posedge link.ceN) begin
		if (link.ceN) begin
			tx <= '0;
		end else begin
			tx <= next_tx;
		end
	end

	assign link.devSdaOut = 1'b0;
	assign link.devSdaOeN = r.sdaOeN;
	assign link.devSdioOut = tx.sh[7];
	assign link.devSdioOeN = ~tx.drv;
	assign regPtr = r.regPtr;
	assign regWrStb = r.regWrStb;
	assign regWdata = r.regWdata;
endmodule : srap_device

/* File: design/srap_host.sv */
// host end: bus master that makes the link clock and runs transfers
`timescale 1ns/100ps
module srap_host #(
	parameter int VARIANT = srap_pkg::VAR_I2C,
	parameter int QTR_CYC = (VARIANT == srap_pkg::VAR_I2C) ? srap_pkg::I2C_QTR_CYC : srap_pkg::SPI_QTR_CYC,
	parameter int GAP_CYC = srap_pkg::SPI_GAP_CYC
) (
	input  wire logic       ref_clk,
	input  wire logic       rst,
	srap_if.host            link,
	input  wire logic       startReq,
	input  wire logic       startRd,
	input  wire logic [7:0] startPtr,
	input  wire logic [7:0] startLen,
	input  wire logic [1:0] devAddr,
	input  wire logic [7:0] txData,
	output logic            txTake,
	output logic [7:0]      rxData,
	output logic            rxValid,
	output logic            busy,
	output logic            nack
);
	typedef enum {H_IDLE, H_START, H_BIT, H_STOP} srapHst_t;

	typedef struct packed {
		srapHst_t   st;
		logic [7:0] tmr;
		logic [1:0] ph;
		logic [3:0] bitIdx;
		logic [7:0] left;
		logic [1:0] stage;
		logic [7:0] sh;
		logic [7:0] ptrByte;
		logic       send;
		logic       rd;
		logic       last;
		logic       sclO;
		logic       ceN;
		logic       sdaOeN;
		logic       sdioOut;
		logic       sdioOeN;
		logic [1:0] sdaSy;
		logic [1:0] sdioSy;
		logic [7:0] rxData;
		logic       rxValid;
		logic       txTake;
		logic       busy;
		logic       nack;
	} srapHost_t;

	localparam logic IS_I2C = (VARIANT == srap_pkg::VAR_I2C);
	localparam logic [7:0] QTR_LD = 8'(QTR_CYC - 1);
	localparam logic [7:0] GAP_LD = 8'(GAP_CYC - 1);
	localparam logic [3:0] LAST_BIT = IS_I2C ? srap_pkg::I2C_BITS - 4'h1 : srap_pkg::SPI_BITS - 4'h1;

	srapHost_t h;
	srapHost_t next_h;

	always_comb begin
		logic smp;
		next_h = h;
		next_h.rxValid = 1'b0;
		next_h.txTake = 1'b0;
		next_h.sdaSy = {h.sdaSy[0], link.sda};
		next_h.sdioSy = {h.sdioSy[0], link.sdio};
		smp = IS_I2C ? h.sdaSy[1] : h.sdioSy[1];
		if (h.st == H_IDLE) begin
			next_h.sclO = IS_I2C;
			next_h.ceN = 1'b1;
			if (startReq) begin
				next_h.busy = 1'b1;
				next_h.nack = 1'b0;
				next_h.rd = startRd;
				next_h.left = startLen;
				next_h.stage = 2'h0;
				next_h.ptrByte = startPtr;
				next_h.send = 1'b1;
				next_h.last = 1'b0;
				next_h.bitIdx = 4'h0;
				next_h.ph = 2'h0;
				next_h.tmr = QTR_LD;
				next_h.st = H_START;
				next_h.sh = IS_I2C ? {srap_pkg::I2C_ADDR_FIXED, devAddr, startRd}
					: {startRd, srap_pkg::SPI_PAD_VAL, startPtr[4:0]};
			end
		end else if (h.tmr != 8'h00) begin
			next_h.tmr = h.tmr - 8'h01;
		end else begin
			next_h.tmr = QTR_LD;
			next_h.ph = h.ph + 2'h1;
			case (h.st)
				H_START: begin
					if (h.ph == 2'h0) begin
						if (IS_I2C) begin
							next_h.sdaOeN = 1'b0;
						end else begin
							next_h.ceN = 1'b0;
						end
					end else if (h.ph == 2'h1) begin
						next_h.sclO = 1'b0;
					end else if (h.ph == 2'h3) begin
						next_h.st = H_BIT;
					end
				end
				H_BIT: begin
					case (h.ph)
						2'h0: begin
							if (h.bitIdx == srap_pkg::I2C_ACK_BIT) begin
								next_h.sdaOeN = h.send | h.last;
							end else if (h.send && IS_I2C) begin
								next_h.sdaOeN = h.sh[7];
							end else if (h.send) begin
								next_h.sdioOeN = 1'b0;
								next_h.sdioOut = h.sh[7];
							end else begin
								next_h.sdaOeN = 1'b1;
								next_h.sdioOeN = 1'b1;
							end
						end
						2'h1: begin
							next_h.sclO = 1'b1;
						end
						2'h2: begin
							if (h.bitIdx < srap_pkg::I2C_ACK_BIT) begin
								next_h.sh = {h.sh[6:0], smp};
							end else if (h.send) begin
								next_h.nack = h.nack | smp;
							end
							if (!IS_I2C && h.bitIdx == 4'h7) begin
								next_h.tmr = GAP_LD;
								if (h.rd) begin
									next_h.sdioOeN = 1'b1;
								end
							end
						end
						default: begin
							next_h.sclO = 1'b0;
							next_h.bitIdx = h.bitIdx + 4'h1;
							if (h.bitIdx == LAST_BIT) begin
								next_h.bitIdx = 4'h0;
								if (!h.send) begin
									next_h.rxData = h.sh;
									next_h.rxValid = 1'b1;
								end
								if (IS_I2C && h.stage == 2'h0 && !h.rd && !h.nack) begin
									next_h.stage = 2'h1;
									next_h.sh = h.ptrByte;
									next_h.send = 1'b1;
								end else if (h.left == 8'h00 || h.nack) begin
									next_h.st = H_STOP;
								end else begin
									next_h.stage = 2'h2;
									next_h.left = h.left - 8'h01;
									next_h.send = !h.rd;
									next_h.last = (h.left == 8'h01);
									if (!h.rd) begin
										next_h.sh = txData;
										next_h.txTake = 1'b1;
									end
								end
							end
						end
					endcase
				end
				H_STOP: begin
					if (h.ph == 2'h0) begin
						next_h.sdaOeN = !IS_I2C;
						next_h.sdioOeN = 1'b1;
					end else if (h.ph == 2'h1) begin
						next_h.sclO = IS_I2C;
					end else if (h.ph == 2'h2) begin
						next_h.sdaOeN = 1'b1;
						next_h.ceN = 1'b1;
					end else begin
						next_h.busy = 1'b0;
						next_h.st = H_IDLE;
					end
				end
				default: begin
					next_h.st = H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk or posedge rst) begin
		if (rst) begin
			h <= '0;
			h.sclO <= IS_I2C;
			h.ceN <= 1'b1;
			h.sdaOeN <= 1'b1;
			h.sdioOeN <= 1'b1;
		end else begin
			h <= next_h;
		end
	end

	assign link.scl = h.sclO;
	assign link.ceN = h.ceN;
	assign link.hostSdaOeN = h.sdaOeN;
	assign link.hostSdioOut = h.sdioOut;
	assign link.hostSdioOeN = h.sdioOeN;
	assign txTake = h.txTake;
	assign rxData = h.rxData;
	assign rxValid = h.rxValid;
	assign busy = h.busy;
	assign nack = h.nack;
endmodule : srap_host

/* File: pkg/srap_if.sv */
// link wires between the host end and the device end
`timescale 1ns/100ps
interface srap_if;
	logic scl;
	logic ceN;
	logic hostSdaOeN;
	logic devSdaOut;
	logic devSdaOeN;
	logic hostSdioOut;
	logic hostSdioOeN;
	logic devSdioOut;
	logic devSdioOeN;
	logic sda;
	logic sdio;

	// open drain with pull-up; shared data line with weak pull-up
	assign sda = (!hostSdaOeN || (!devSdaOeN && !devSdaOut)) ? 1'b0 : 1'b1;
	assign sdio = !hostSdioOeN ? hostSdioOut : (!devSdioOeN ? devSdioOut : 1'b1);

	modport host (output scl, output ceN, output hostSdaOeN, output hostSdioOut, output hostSdioOeN,
		input sda, input sdio);
	modport dev (input scl, input ceN, input sda, input sdio,
		output devSdaOut, output devSdaOeN, output devSdioOut, output devSdioOeN);
endinterface : srap_if

/* File: pkg/srap_pkg.sv */
// shared constants and helpers of the serial register access port
package srap_pkg;
	localparam int VAR_I2C = 0;
	localparam int VAR_SPI = 1;
	localparam logic [4:0] PTR_LAST = 5'h0f;
	localparam logic [4:0] PTR_SAT = 5'h10;
	localparam logic [4:0] I2C_ADDR_FIXED = 5'h0e;
	localparam int I2C_DIR_BIT = 0;
	localparam int SPI_DIR_BIT = 7;
	localparam logic [1:0] SPI_PAD_VAL = 2'h0;
	localparam logic [3:0] I2C_ACK_BIT = 4'h8;
	localparam logic [3:0] I2C_BITS = 4'h9;
	localparam logic [3:0] SPI_BITS = 4'h8;
	localparam int REF_CLK_MHZ = 50;
	localparam int I2C_QTR_NS = 625;
	localparam int SPI_QTR_NS = 50;
	localparam int SPI_GAP_NS = 200;
	localparam int I2C_QTR_CYC = (I2C_QTR_NS * REF_CLK_MHZ + 999) / 1000;
	localparam int SPI_QTR_CYC = (SPI_QTR_NS * REF_CLK_MHZ + 999) / 1000;
	localparam int SPI_GAP_CYC = (SPI_GAP_NS * REF_CLK_MHZ + 999) / 1000;

	// pointer step that parks at the saturation value
	function automatic logic [4:0] ptrNext(input logic [4:0] p);
		ptrNext = (p == PTR_SAT) ? p : p + 5'h01;
	endfunction : ptrNext

	// read byte for a pointer, zero once parked
	function automatic logic [7:0] rdSel(input logic [4:0] p, input logic [7:0] d);
		rdSel = (p == PTR_SAT) ? 8'h00 : d;
	endfunction : rdSel
endpackage : srap_pkg
